// >>> design/digital_line_output_enable.sv
// Overview of operation
// - Enable bit n-1 controls line n; twenty lines, bits 19 down to 0.
// - Enable bit clear releases the line driver; set turns the driver on.
// - An enabled line is driven at its bit of the output-level register.
// - Every line receiver stays enabled whatever the driver state.
// - Every line level is readable at any time via the input register.
// - Enable bits are read/write and reset to zero, all drivers off.
// - Level bit matters only while enabled; zero drives the line low.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "line_io_params.svh"

module digital_line_output_enable #(
    parameter int LINES = `LINE_COUNT,
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LINES-1:0] lineIn,
    output logic [LINES-1:0] lineOut,
    output logic [LINES-1:0] lineOutEn
);
    import line_io_pkg::*;

    // ------------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------------
    // Unmapped words answer with an error and read zero; the input word
    // ignores writes without an error, so a whole-bank write is harmless.
    localparam logic [ADDR_W-1:0] ADDR_INPUT = ADDR_W'(`LINE_OFF_INPUT);
    localparam logic [ADDR_W-1:0] ADDR_LEVEL = ADDR_W'(`LINE_OFF_LEVEL);
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = ADDR_W'(`LINE_OFF_ENABLE);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        bus_phase_type phase;
        reg_sel_type sel;
        logic [31:0] rdata;
        logic slverr;
        logic [LINES-1:0] lineLevel;
    } top_state_type;

    top_state_type state_r;
    top_state_type state_nxt;

    line_drive_if #(.LINES(LINES)) drive ();

    logic setupPhase;
    logic accessDone;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] a;
        a = addr;
        if (a == ADDR_INPUT) begin
            decode = SEL_INPUT;
        end else if (a == ADDR_LEVEL) begin
            decode = SEL_LEVEL;
        end else if (a == ADDR_ENABLE) begin
            decode = SEL_ENABLE;
        end else begin
            decode = SEL_NONE;
        end
    endfunction

    // Byte strobes to a bit mask
    function automatic logic [31:0] laneMask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = 8'hff;
            end
        end
        laneMask = m;
    endfunction

    // Narrow line vector into the low bits of a word, upper bits zero
    function automatic logic [31:0] widen(input logic [LINES-1:0] v);
        logic [31:0] w;
        w = 32'h00000000;
        w[`LINE_FIELD_LSB +: LINES] = v;
        widen = w;
    endfunction

    // Read word of a register; the enable word reads its upper bits as zero
    function automatic logic [31:0] readBack(
        input reg_sel_type sel,
        input logic [LINES-1:0] pins,
        input logic [LINES-1:0] level,
        input logic [LINES-1:0] enable
    );
        logic [31:0] w;
        w = `LINE_RDATA_RESET;
        unique case (sel)
            SEL_INPUT: begin
                w = widen(pins);
            end
            SEL_LEVEL: begin
                w = widen(level);
            end
            SEL_ENABLE: begin
                w = widen(enable);
            end
            SEL_NONE: begin
                w = `LINE_RDATA_RESET;
            end
        endcase
        readBack = w;
    endfunction

    // Only the level and enable words hold state; other words drop writes
    function automatic logic writable(input reg_sel_type sel);
        writable = (sel == SEL_LEVEL) || (sel == SEL_ENABLE);
    endfunction

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    // One wait-free access phase: the setup edge decodes and latches read
    // data, so prdata comes from a flop without costing an extra cycle.
    assign setupPhase = psel && !penable;
    assign pready = psel && penable && (state_r.phase == PH_READY);
    assign accessDone = pready;
    // Held from setup to the next setup, so a late sampler still sees it
    assign prdata = state_r.rdata;
    assign pslverr = pready && state_r.slverr;

    always_comb begin
        state_nxt = state_r;
        // Receivers are never gated; sampled every cycle
        state_nxt.lineLevel = lineIn;
        unique case (state_r.phase)
            PH_IDLE: begin
                if (setupPhase) begin
                    state_nxt.phase = PH_READY;
                    state_nxt.sel = decode(paddr);
                    state_nxt.slverr = (decode(paddr) == SEL_NONE);
                    state_nxt.rdata = `LINE_RDATA_RESET;
                    if (!pwrite) begin
                        // Driven lines read back their pin level too
                        state_nxt.rdata = readBack(decode(paddr), state_r.lineLevel,
                            drive.driveLevel, drive.driveEnable);
                    end
                end
            end
            PH_READY: begin
                if (accessDone) begin
                    state_nxt.phase = PH_IDLE;
                end else if (!psel) begin
                    // Master gave up mid-transfer; start over cleanly
                    state_nxt.phase = PH_IDLE;
                end
            end
            default: begin
                state_nxt.phase = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r.phase <= PH_IDLE;
            state_r.sel <= SEL_NONE;
            state_r.rdata <= `LINE_RDATA_RESET;
            state_r.slverr <= 1'b0;
            state_r.lineLevel <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Write path
    // ------------------------------------------------------------------------
    // Writes land only at the edge that completes the access phase; the
    // input register and unmapped words ignore them.
    assign drive.wrStrobe = accessDone && pwrite && writable(state_r.sel);
    assign drive.wrSel = state_r.sel;
    assign drive.wrData = pwdata;
    // Unstrobed lanes keep their stored bits
    assign drive.wrMask = laneMask(pstrb);

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    line_drive_regs #(
        .LINES(LINES)
    ) u_regs (
        .clk(clk),
        .reset(reset),
        .regs(drive.store)
    );

    // ------------------------------------------------------------------------
    // Line drivers
    // ------------------------------------------------------------------------
    // The input side is never gated, so a line that fights the far side
    // reads back the level it really has, not the one asked for.
    // Enable bit i is the driver of line i+1
    assign lineOutEn = drive.driveEnable;
    // Level is presented even when released; the enable alone gates the pin,
    // so lineOut of a disabled line still carries the stored level
    assign lineOut = drive.driveLevel;

endmodule

`default_nettype wire

// >>> design/line_drive_if.sv
`timescale 1ns/1ns
`default_nettype none

interface line_drive_if #(
    parameter int LINES = 20
);
    import line_io_pkg::*;

    logic wrStrobe;
    reg_sel_type wrSel;
    logic [31:0] wrData;
    logic [31:0] wrMask;
    logic [LINES-1:0] driveEnable;
    logic [LINES-1:0] driveLevel;

    modport ctrl (
        output wrStrobe,
        output wrSel,
        output wrData,
        output wrMask,
        input driveEnable,
        input driveLevel
    );

    modport store (
        input wrStrobe,
        input wrSel,
        input wrData,
        input wrMask,
        output driveEnable,
        output driveLevel
    );

endinterface

`default_nettype wire

// >>> design/line_drive_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "line_io_params.svh"

module line_drive_regs #(
    parameter int LINES = 20
) (
    input wire logic clk,
    input wire logic reset,
    line_drive_if.store regs
);
    import line_io_pkg::*;

    typedef struct packed {
        logic [LINES-1:0] enable;
        logic [LINES-1:0] level;
    } store_state_type;

    store_state_type state_r;
    store_state_type state_nxt;

    // ------------------------------------------------------------------------
    // Masked update of the two software registers
    // ------------------------------------------------------------------------
    function automatic logic [LINES-1:0] merge(
        input logic [LINES-1:0] old,
        input logic [31:0] data,
        input logic [31:0] mask
    );
        logic [LINES-1:0] d;
        logic [LINES-1:0] m;
        d = data[`LINE_FIELD_LSB +: LINES];
        m = mask[`LINE_FIELD_LSB +: LINES];
        merge = (old & ~m) | (d & m);
    endfunction

    always_comb begin
        state_nxt = state_r;
        if (regs.wrStrobe) begin
            // Bits above the last line are never stored, so they stay zero
            if (regs.wrSel == SEL_ENABLE) begin
                state_nxt.enable = merge(state_r.enable, regs.wrData, regs.wrMask);
            end
            if (regs.wrSel == SEL_LEVEL) begin
                state_nxt.level = merge(state_r.level, regs.wrData, regs.wrMask);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r.enable <= LINES'(`LINE_ENABLE_RESET);
            state_r.level <= LINES'(`LINE_LEVEL_RESET);
        end else begin
            state_r <= state_nxt;
        end
    end

    assign regs.driveEnable = state_r.enable;
    assign regs.driveLevel = state_r.level;

endmodule

`default_nettype wire

// >>> design/line_io_params.svh
`ifndef LINE_IO_PARAMS_SVH
`define LINE_IO_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define LINE_OFF_INPUT 12'h358
`define LINE_OFF_LEVEL 12'h35c
`define LINE_OFF_ENABLE 12'h360

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define LINE_COUNT 20
`define LINE_FIELD_LSB 0
`define LINE_ENABLE_RESET 20'h00000
`define LINE_LEVEL_RESET 20'h00000
`define LINE_RDATA_RESET 32'h00000000

`endif

// >>> design/line_io_pkg.sv
package line_io_pkg;

    // Bus transfer progress of the register slave
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_READY = 2'b01
    } bus_phase_type;

    // Register selected by a bus address
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_INPUT = 2'b01,
        SEL_LEVEL = 2'b10,
        SEL_ENABLE = 2'b11
    } reg_sel_type;

endpackage

// >>> verif/line_io_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "line_io_params.svh"

module line_io_checker #(
    parameter int LINES = 20,
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [LINES-1:0] lineIn,
    input wire logic [LINES-1:0] lineOut,
    input wire logic [LINES-1:0] lineOutEn
);
    // ------
    // Bus and line relations
    // ------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic done;
    logic known;
    assign done = psel && penable && pready;
    assign known = paddr == `LINE_OFF_INPUT || paddr == `LINE_OFF_LEVEL
        || paddr == `LINE_OFF_ENABLE;

    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("No ready after setup");
    a_reset_off: assert property ($fell(reset) |-> lineOutEn == '0)
        else $error("Drivers on after reset");
    a_enable_write: assert property (done && pwrite && paddr == `LINE_OFF_ENABLE && pstrb == 4'hf
        |=> lineOutEn == $past(pwdata[LINES-1:0]))
        else $error("Enable write lost");
    a_level_write: assert property (done && pwrite && paddr == `LINE_OFF_LEVEL && pstrb == 4'hf
        |=> lineOut == $past(pwdata[LINES-1:0]))
        else $error("Level write lost");
    a_enable_hold: assert property (!(done && pwrite && paddr == `LINE_OFF_ENABLE)
        |=> $stable(lineOutEn))
        else $error("Enable changed unasked");
    a_enable_read: assert property (done && !pwrite && paddr == `LINE_OFF_ENABLE
        |-> prdata == 32'(lineOutEn))
        else $error("Enable read wrong");
    a_input_read: assert property (done && !pwrite && paddr == `LINE_OFF_INPUT
        |-> prdata == 32'($past(lineIn, 2)))
        else $error("Input read wrong");
    a_unmapped_err: assert property (done |-> pslverr == !known)
        else $error("Error response wrong");

    c_enable_write: cover property (done && pwrite && paddr == `LINE_OFF_ENABLE);
    c_input_read: cover property (done && !pwrite && paddr == `LINE_OFF_INPUT);
    c_unmapped: cover property (done && pslverr);
endmodule

`default_nettype wire

// >>> verif/line_partner.sv
`timescale 1ns/1ns
`default_nettype none

module line_partner #(
    parameter int LINES = 20
) (
    input wire logic [LINES-1:0] lineOut,
    input wire logic [LINES-1:0] lineOutEn,
    input wire logic [LINES-1:0] farLevel,
    output wire logic [LINES-1:0] lineIn
);
    // ------
    // Wire level
    // ------
    // Far side always drives; the device wins only where its driver is on
    assign lineIn = (lineOutEn & lineOut) | (~lineOutEn & farLevel);
endmodule

`default_nettype wire

// >>> verif/tb_digital_line_output_enable.sv
`timescale 1ns/1ns
`default_nettype none
`include "line_io_params.svh"

module tb_digital_line_output_enable;
    localparam logic [11:0] ENA = `LINE_OFF_ENABLE;
    localparam logic [11:0] LVL = `LINE_OFF_LEVEL;
    localparam logic [11:0] INP = `LINE_OFF_INPUT;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [19:0] farLevel = 20'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [19:0] lineIn;
    logic [19:0] lineOut;
    logic [19:0] lineOutEn;
    logic [33:0] expQ[$];
    logic [33:0] ent;
    logic [19:0] en;
    logic [19:0] lv;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 32'h65fe;

    digital_line_output_enable #(.LINES(20), .ADDR_W(12)) dut (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lineIn(lineIn), .lineOut(lineOut), .lineOutEn(lineOutEn));
    line_partner #(.LINES(20)) far (.lineOut(lineOut), .lineOutEn(lineOutEn),
        .farLevel(farLevel), .lineIn(lineIn));

    initial begin
        forever #20 clk = ~clk;
    end

    // ------
    // Checking and bus tasks
    // ------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [31:0] exp, input logic err);
        int n;
        logic seen;
        @(posedge clk);
        expQ.push_back({!wr, err, exp});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        n = 0;
        seen = 1'b0;
        while (!seen && n < 50) begin
            @(posedge clk);
            seen = (pready === 1'b1);
            n++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!seen) begin
            fail_count++;
            give_verdict();
        end
    endtask

    // Answers are taken at the rising edge that completes the access
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            ent = expQ.pop_front();
            check({31'h0, pslverr}, {31'h0, ent[32]});
            if (ent[33]) begin
                check(prdata, ent[31:0]);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        give_verdict();
    end

    // ------
    // Scenarios
    // ------
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, ENA, 32'h0, 4'h0, 32'h0, 1'b0);
        apb(1'b0, LVL, 32'h0, 4'h0, 32'h0, 1'b0);
        check(32'(lineOutEn), 32'h0);
        for (int i = 0; i < 20; i++) begin
            apb(1'b1, ENA, 32'h1 << i, 4'hf, 32'h0, 1'b0);
            @(negedge clk);
            check(32'(lineOutEn), 32'h1 << i);
        end
        apb(1'b1, ENA, 32'hffffffff, 4'hf, 32'h0, 1'b0);
        apb(1'b0, ENA, 32'h0, 4'h0, 32'h000fffff, 1'b0);
        apb(1'b1, ENA, 32'h0, 4'h2, 32'h0, 1'b0);
        apb(1'b0, ENA, 32'h0, 4'h0, 32'h000f00ff, 1'b0);
        for (int k = 0; k < 8; k++) begin
            en = 20'($random(seed));
            lv = 20'($random(seed));
            farLevel <= 20'($random(seed));
            apb(1'b1, LVL, {12'h0, lv}, 4'hf, 32'h0, 1'b0);
            apb(1'b1, ENA, {12'h0, en}, 4'hf, 32'h0, 1'b0);
            apb(1'b0, LVL, 32'h0, 4'h0, {12'h0, lv}, 1'b0);
            apb(1'b0, INP, 32'h0, 4'h0, {12'h0, (en & lv) | (~en & farLevel)}, 1'b0);
            check(32'(lineOut & lineOutEn), 32'(lv & en));
        end
        apb(1'b1, INP, 32'hffffffff, 4'hf, 32'h0, 1'b0);
        apb(1'b0, 12'h364, 32'h0, 4'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h364, 32'hffffffff, 4'hf, 32'h0, 1'b1);
        apb(1'b0, ENA, 32'h0, 4'h0, {12'h0, en}, 1'b0);
        @(posedge clk);
        reset <= 1'b1;
        @(negedge clk);
        check(32'(lineOutEn), 32'h0);
        @(posedge clk);
        reset <= 1'b0;
        apb(1'b0, ENA, 32'h0, 4'h0, 32'h0, 1'b0);
        @(negedge clk);
        give_verdict();
    end
endmodule

bind digital_line_output_enable line_io_checker #(.LINES(LINES), .ADDR_W(ADDR_W)) chk (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lineIn(lineIn), .lineOut(lineOut), .lineOutEn(lineOutEn));

`default_nettype wire
